// file: hw/iwdg_defs.svh
// Purpose: offsets, key codes, reset values and timing counts of the watchdog
// Assumes: byte offsets on a 5-bit register address
// Notes:   definitions only
`ifndef IWDG_DEFS_SVH
`define IWDG_DEFS_SVH

`define IWDG_ADDR_W      5
`define IWDG_OFS_KEY     5'h00
`define IWDG_OFS_PSC     5'h04
`define IWDG_OFS_RLD     5'h08
`define IWDG_OFS_STAT    5'h0C
`define IWDG_OFS_WND     5'h10

`define IWDG_KEY_UNLOCK  16'h5555
`define IWDG_KEY_START   16'hCCCC
`define IWDG_KEY_RELOAD  16'hAAAA

`define IWDG_PSC_W       3
`define IWDG_CNT_W       12
`define IWDG_PRE_W       8
`define IWDG_PSC_RST     3'h0
`define IWDG_RLD_RST     12'hFFF
`define IWDG_WND_RST     12'hFFF

`define IWDG_STAT_PSC    0
`define IWDG_STAT_RLD    1
`define IWDG_STAT_WND    2

// oscillator ticks a value takes to reach the counter domain
`define IWDG_UPD_TICKS   2'h2

`endif

// file: hw/iwdg_pkg.sv
// Purpose: state types of the watchdog modules
// Assumes: iwdg_defs.svh
// Notes:   one packed struct each for iwdg_regs and iwdg_sync
`include "iwdg_defs.svh"
`default_nettype none

package iwdg_pkg;

	typedef logic [`IWDG_CNT_W-1:0] iwdg_cnt_t;

	typedef struct packed {
		logic                    unlocked;
		logic                    running;
		logic                    rst;
		iwdg_cnt_t               cnt;
		logic [`IWDG_PRE_W-1:0]  pre;
		logic [31:0]             rdata;
	} iwdg_core_s;

	typedef struct packed {
		logic [1:0] pipe;
		logic       last;
	} iwdg_sync_s;

endpackage : iwdg_pkg

`default_nettype wire

// file: hw/iwdg_upd_if.sv
// Purpose: carries one write-protected value into the counter domain
// Assumes: one clock shared by both ends
// Notes:   ctl side writes, chan side reports pending and the live value
`default_nettype none

interface iwdg_upd_if #(parameter int W = 12);
	logic         wr;
	logic [W-1:0] wdata;
	logic         tick;
	logic         pending;
	logic [W-1:0] value;
	logic         done;

	modport ctl  (output wr, output wdata, output tick, input pending, input value, input done);
	modport chan (input wr, input wdata, input tick, output pending, output value, output done);
endinterface : iwdg_upd_if

`default_nettype wire

// file: hw/iwdg_sync.sv
// Purpose: two-flop synchroniser of the oscillator pin with rising-edge tick
// Assumes: oscillator far slower than ref_clk
// Notes:   edge detect reads only the second stage
`default_nettype none

module iwdg_sync
	import iwdg_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// pin and tick
	input  wire logic pin_in,
	output logic      tick
);

	iwdg_sync_s s_r;
	iwdg_sync_s s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.pipe = {s_r.pipe[0], pin_in};
		s_nxt.last = s_r.pipe[1];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.pipe[1] & ~s_r.last;

	AST_TICK_ONE: assert property (@(posedge ref_clk) disable iff (sys_rst) tick |=> !tick)
		else $error("oscillator tick lasted more than one cycle");

endmodule : iwdg_sync

`default_nettype wire

// file: hw/iwdg_upd.sv
// Purpose: update channel: stage a write, hold pending, apply after osc ticks
// Assumes: tick is a one-cycle pulse per oscillator edge
// Notes:   a write landing on the completing cycle restarts the transfer
`default_nettype none

module iwdg_upd
	import iwdg_pkg::*;
#(
	parameter int          W   = 12,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// channel
	iwdg_upd_if.chan  ch
);

	typedef struct packed {
		logic         pending;
		logic [1:0]   ticks;
		logic [W-1:0] staged;
		logic [W-1:0] value;
		logic         done;
	} iwdg_upd_s;

	iwdg_upd_s s_r;
	iwdg_upd_s s_nxt;

	initial begin
		if (W < 1 || W > 32) $error("iwdg_upd: width out of range");
	end

	always_comb begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;
		if (s_r.pending && ch.tick) begin
			if (s_r.ticks == `IWDG_UPD_TICKS - 2'h1) begin
				s_nxt.value   = s_r.staged;
				s_nxt.pending = 1'b0;
				s_nxt.done    = 1'b1;
			end else begin
				s_nxt.ticks = s_r.ticks + 2'h1;
			end
		end
		// set wins over the clear
		if (ch.wr) begin
			s_nxt.staged  = ch.wdata;
			s_nxt.pending = 1'b1;
			s_nxt.ticks   = 2'h0;
			s_nxt.done    = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_r         <= '0;
			s_r.value   <= RST;
			s_r.staged  <= RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ch.pending = s_r.pending;
	assign ch.value   = s_r.value;
	assign ch.done    = s_r.done;

	sequence s_upd_write;
		ch.wr;
	endsequence

	sequence s_upd_hold;
		ch.pending [*2];
	endsequence

	AST_UPD_SET: assert property (@(posedge ref_clk) disable iff (sys_rst) s_upd_write |=> s_upd_hold)
		else $error("update flag not held after write");
	AST_UPD_DONE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ch.done |-> !ch.pending && ch.value == $past(s_r.staged))
		else $error("update completed without applying staged value");

endmodule : iwdg_upd

`default_nettype wire

// file: hw/iwdg_regs.sv
// Purpose: independent watchdog: key commands, protected registers, 12-bit down-counter
// Assumes: low_speed_oscillator arrives as a pin, sampled into ref_clk
// Notes:   reset request stays high until sys_rst
`include "iwdg_defs.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - key register low 16 bits act as commands; upper bits and reads ignored.
// - key 0x5555 unlocks prescaler, reload and window writes.
// - key 0xCCCC starts counter; reaching zero requests system reset.
// - key 0xAAAA loads counter with current reload value.
// - prescaler bits 2:0 divide by 4 to 128, codes 110 and 111 by 256.
// - status bit 0 high while a prescaler write is in transfer.
// - status bit 1 high while a reload write is in transfer.
// - status bit 2 high while a window write is in transfer.
// - reload value sits in bits 11:0; upper bits read zero.
// - reload while running and counter above window limit requests system reset.
// - window writes refused while a window update is pending.
// - any key other than unlock relocks the protected registers.
// - a window change performs a reload and restarts the prescaler.
// - 12-bit counter steps on prescaled oscillator ticks.
module iwdg_regs
	import iwdg_pkg::*;
(
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	// register port
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [`IWDG_ADDR_W-1:0]  reg_addr,
	input  wire logic [31:0]              reg_wdata,
	output logic      [31:0]              reg_rdata,
	// oscillator pin
	input  wire logic                     low_speed_oscillator,
	// watchdog outputs
	output logic                          wdg_reset_req,
	output logic                          wdg_running
);

	////////////////////////////////////////////////////////////////////////////
	// channels

	iwdg_core_s s_r;
	iwdg_core_s s_nxt;
	logic       osc_tick;

	iwdg_upd_if #(.W(`IWDG_PSC_W)) psc_if ();
	iwdg_upd_if #(.W(`IWDG_CNT_W)) rld_if ();
	iwdg_upd_if #(.W(`IWDG_CNT_W)) wnd_if ();

	iwdg_sync u_sync (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pin_in  (low_speed_oscillator),
		.tick    (osc_tick)
	);

	iwdg_upd #(.W(`IWDG_PSC_W), .RST(`IWDG_PSC_RST)) u_psc (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.ch      (psc_if)
	);

	iwdg_upd #(.W(`IWDG_CNT_W), .RST(`IWDG_RLD_RST)) u_rld (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.ch      (rld_if)
	);

	iwdg_upd #(.W(`IWDG_CNT_W), .RST(`IWDG_WND_RST)) u_wnd (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.ch      (wnd_if)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode

	logic        key_wr;
	logic [15:0] key_val;
	logic        win_viol;
	logic        pre_last;

	function automatic logic [`IWDG_PRE_W-1:0] div_last(input logic [`IWDG_PSC_W-1:0] sel);
		logic [`IWDG_PRE_W-1:0] d;
		d = 8'hFF;
		if (sel < 3'h6) begin
			d = (8'h04 << sel) - 8'h01;
		end
		return d;
	endfunction : div_last

	assign key_wr   = reg_wr && reg_addr == `IWDG_OFS_KEY;
	assign key_val  = reg_wdata[15:0];
	assign win_viol = s_r.running && s_r.cnt > wnd_if.value;
	// >= so a smaller divider applied mid-count does not wait for the wrap
	assign pre_last = s_r.pre >= div_last(psc_if.value);

	// locked writes never start a transfer
	assign psc_if.wr    = reg_wr && reg_addr == `IWDG_OFS_PSC && s_r.unlocked;
	assign rld_if.wr    = reg_wr && reg_addr == `IWDG_OFS_RLD && s_r.unlocked;
	assign wnd_if.wr    = reg_wr && reg_addr == `IWDG_OFS_WND && s_r.unlocked
	                      && !wnd_if.pending;
	assign psc_if.wdata = reg_wdata[`IWDG_PSC_W-1:0];
	assign rld_if.wdata = reg_wdata[`IWDG_CNT_W-1:0];
	assign wnd_if.wdata = reg_wdata[`IWDG_CNT_W-1:0];
	assign psc_if.tick  = osc_tick;
	assign rld_if.tick  = osc_tick;
	assign wnd_if.tick  = osc_tick;

	////////////////////////////////////////////////////////////////////////////
	// counter and commands

	always_comb begin
		s_nxt = s_r;
		if (s_r.running && osc_tick) begin
			if (pre_last) begin
				s_nxt.pre = '0;
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 12'h001;
				end
			end else begin
				s_nxt.pre = s_r.pre + 8'h01;
			end
		end
		if (s_r.running && s_r.cnt == '0) begin
			s_nxt.rst = 1'b1;
		end
		if (wnd_if.done) begin
			s_nxt.cnt = rld_if.value;
			s_nxt.pre = '0;
		end
		if (key_wr) begin
			s_nxt.unlocked = key_val == `IWDG_KEY_UNLOCK;
			if (key_val == `IWDG_KEY_START) begin
				s_nxt.running = 1'b1;
			end
			if (key_val == `IWDG_KEY_RELOAD) begin
				s_nxt.cnt = rld_if.value;
				s_nxt.pre = '0;
				if (win_viol) begin
					s_nxt.rst = 1'b1;
				end
			end
		end
		// pending fields return the old live value
		if (reg_rd) begin
			case (reg_addr)
				`IWDG_OFS_PSC:  s_nxt.rdata = {29'h0, psc_if.value};
				`IWDG_OFS_RLD:  s_nxt.rdata = {20'h0, rld_if.value};
				`IWDG_OFS_WND:  s_nxt.rdata = {20'h0, wnd_if.value};
				`IWDG_OFS_STAT: s_nxt.rdata = {29'h0, wnd_if.pending, rld_if.pending,
				                               psc_if.pending};
				default:        s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_r     <= '0;
			s_r.cnt <= `IWDG_RLD_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata     = s_r.rdata;
	assign wdg_reset_req = s_r.rst;
	assign wdg_running   = s_r.running;

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_key(logic [15:0] k);
		key_wr && key_val == k;
	endsequence

	AST_KEY_UNLOCK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_key(`IWDG_KEY_UNLOCK) |=> s_r.unlocked)
		else $error("unlock key did not open protected registers");
	AST_KEY_RELOCK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		key_wr && key_val != `IWDG_KEY_UNLOCK |=> !s_r.unlocked)
		else $error("other key left registers unlocked");
	AST_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_key(`IWDG_KEY_START) |=> wdg_running [*2])
		else $error("start key did not start counter");
	AST_EXPIRE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_r.running && s_r.cnt == '0 |=> wdg_reset_req)
		else $error("expired counter gave no reset");
	AST_RELOAD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_key(`IWDG_KEY_RELOAD) |=> s_r.cnt == $past(rld_if.value) && s_r.pre == '0)
		else $error("reload key did not load counter");
	AST_WIN_VIOL: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_key(`IWDG_KEY_RELOAD) and win_viol |=> wdg_reset_req)
		else $error("reload above window gave no reset");
	AST_WIN_RELOAD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wnd_if.done && !key_wr |=> s_r.cnt == $past(rld_if.value))
		else $error("window change did not reload counter");
	AST_LOCKED_PSC: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_wr && reg_addr == `IWDG_OFS_PSC && !s_r.unlocked && !psc_if.pending
		|=> !psc_if.pending)
		else $error("locked prescaler write was taken");
	AST_WND_BUSY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wnd_if.pending && !wnd_if.done |-> !wnd_if.wr)
		else $error("window write taken while update pending");
	AST_DECR: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_r.running && osc_tick && pre_last && s_r.cnt != '0 && !key_wr && !wnd_if.done
		|=> s_r.cnt == $past(s_r.cnt) - 12'h001)
		else $error("counter missed its prescaled step");

	////////////////////////////////////////////////////////////////////////////
	// read path checks

	sequence s_rd(logic [`IWDG_ADDR_W-1:0] a);
		reg_rd && reg_addr == a;
	endsequence

	AST_KEY_RD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_rd(`IWDG_OFS_KEY) |=> reg_rdata == 32'h0000_0000)
		else $error("key register read back nonzero");
	AST_PSC_RD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_rd(`IWDG_OFS_PSC) |=> reg_rdata[31:3] == 29'h0000_0000)
		else $error("prescaler read shows reserved bits");
	AST_RLD_RD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_rd(`IWDG_OFS_RLD) |=> reg_rdata[31:12] == 20'h0_0000)
		else $error("reload read shows reserved bits");
	AST_WND_RD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_rd(`IWDG_OFS_WND) |=> reg_rdata[31:12] == 20'h0_0000)
		else $error("window read shows reserved bits");
	AST_STAT_RD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_rd(`IWDG_OFS_STAT) |=> reg_rdata == {29'h0000_0000, $past(wnd_if.pending),
		                                      $past(rld_if.pending), $past(psc_if.pending)})
		else $error("status read does not match update flags");
	// read data must not drift between reads
	AST_RDATA_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	////////////////////////////////////////////////////////////////////////////
	// update flag checks

	AST_PSC_FLAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
		psc_if.wr |=> psc_if.pending)
		else $error("prescaler write did not raise its flag");
	AST_RLD_FLAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rld_if.wr |=> rld_if.pending)
		else $error("reload write did not raise its flag");
	AST_WND_FLAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wnd_if.wr |=> wnd_if.pending)
		else $error("window write did not raise its flag");
	AST_LOCKED_RLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_wr && reg_addr == `IWDG_OFS_RLD && !s_r.unlocked |-> !rld_if.wr)
		else $error("locked reload write was taken");
	AST_LOCKED_WND: assert property (@(posedge ref_clk) disable iff (sys_rst)
		reg_wr && reg_addr == `IWDG_OFS_WND && !s_r.unlocked |-> !wnd_if.wr)
		else $error("locked window write was taken");

	////////////////////////////////////////////////////////////////////////////
	// counter and reset request checks

	// no stop command exists, so both levels are sticky
	AST_RUN_STICKY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wdg_running |=> wdg_running)
		else $error("running flag dropped");
	AST_RST_STICKY: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wdg_reset_req |=> wdg_reset_req)
		else $error("reset request dropped");
	AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!wdg_running && !wdg_reset_req |=> !wdg_reset_req)
		else $error("reset request before start");
	AST_WIN_OK: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_key(`IWDG_KEY_RELOAD) and (!win_viol && !wdg_reset_req && !(s_r.running && s_r.cnt == '0))
		|=> !wdg_reset_req)
		else $error("reload inside window gave a reset");
	AST_PRE_CLR: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wnd_if.done && !key_wr |=> s_r.pre == '0)
		else $error("window change did not restart prescaler");

endmodule : iwdg_regs

`default_nettype wire

// file: dv/tb.sv
// Purpose: self-checking bench of the watchdog register block
// Assumes: oscillator sped up to an 80 ns period so that timeouts fit a short run
// Notes:   bench drives inputs on the falling edge; oscillator runs free, unrelated in phase
`include "iwdg_defs.svh"
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int RLD_SHORT = 5;
	localparam int TICKS_EXP = RLD_SHORT * 4;

	logic                    ref_clk;
	logic                    sys_rst;
	logic                    reg_wr;
	logic                    reg_rd;
	logic [`IWDG_ADDR_W-1:0] reg_addr;
	logic [31:0]             reg_wdata;
	logic [31:0]             reg_rdata;
	logic [31:0]             rv;
	logic                    osc;
	logic                    rst_req;
	logic                    running;
	int                      bad_count;
	int                      tests_run;
	int                      ticks;
	int                      t0;
	int                      n;

	iwdg_regs iwdg_regs_i (
		.ref_clk              (ref_clk),
		.sys_rst              (sys_rst),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_rdata            (reg_rdata),
		.low_speed_oscillator (osc),
		.wdg_reset_req        (rst_req),
		.wdg_running          (running)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// odd start offset keeps oscillator edges off the clock edges
	initial begin
		osc = 1'b0;
		#1.3;
		forever #40 osc = ~osc;
	end

	initial ticks = 0;
	always @(posedge osc) ticks <= ticks + 1;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(negedge ref_clk);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
		@(negedge ref_clk);
		reg_rd   = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		rv     = reg_rdata;
		check(what, rv, exp);
	endtask : rchk

	// polls status; a flag that never clears counts as one mismatch
	task automatic wait_clr(input int b);
		int k;
		k = 0;
		do begin
			@(negedge ref_clk);
			reg_rd   = 1'b1;
			reg_addr = `IWDG_OFS_STAT;
			@(negedge ref_clk);
			reg_rd = 1'b0;
			k++;
		end while (reg_rdata[b] !== 1'b0 && k < 300);
		check("flag clear", {31'h0, reg_rdata[b]}, 32'h0);
	endtask : wait_clr

	task automatic do_reset(input int cycles);
		@(negedge ref_clk);
		sys_rst = 1'b1;
		repeat (cycles) @(negedge ref_clk);
		sys_rst = 1'b0;
	endtask : do_reset

	task automatic done(input string name);
		$display("test %s done, mismatches so far %0d", name, bad_count);
	endtask : done

	// one timeout run: divider code, reload count, then ticks until the reset request
	task automatic expiry(input string name, input logic [31:0] sel, input int exp_ticks);
		do_reset(2);
		wr(`IWDG_OFS_KEY, 32'h0000_5555);
		wr(`IWDG_OFS_PSC, sel);
		wr(`IWDG_OFS_RLD, 32'(RLD_SHORT));
		wait_clr(`IWDG_STAT_PSC);
		wait_clr(`IWDG_STAT_RLD);
		wr(`IWDG_OFS_KEY, 32'h0000_AAAA);
		t0 = ticks;
		wr(`IWDG_OFS_KEY, 32'hABCD_CCCC);
		@(negedge ref_clk);
		check("started", {31'h0, running}, 32'h1);
		n = 0;
		while (rst_req !== 1'b1 && n < 4000) begin
			@(negedge ref_clk);
			n++;
		end
		check(name, {31'h0, (ticks - t0 >= exp_ticks - 4) && (ticks - t0 <= exp_ticks + 1)}, 32'h1);
		done(name);
	endtask : expiry

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst   = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 5'h00;
		reg_wdata = 32'h0;
		bad_count = 0;
		tests_run = 0;
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;

		rchk("key read", `IWDG_OFS_KEY, 32'h0);
		rchk("prescaler reset", `IWDG_OFS_PSC, 32'h0);
		rchk("reload reset", `IWDG_OFS_RLD, 32'h0000_0FFF);
		rchk("status reset", `IWDG_OFS_STAT, 32'h0);
		rchk("window reset", `IWDG_OFS_WND, 32'h0000_0FFF);
		rchk("unmapped", 5'h14, 32'h0);
		check("idle running", {31'h0, running}, 32'h0);
		done("reset values");

		wr(`IWDG_OFS_RLD, 32'h0000_0123);
		rchk("locked reload", `IWDG_OFS_RLD, 32'h0000_0FFF);
		wr(`IWDG_OFS_KEY, 32'h0000_5555);
		wr(`IWDG_OFS_RLD, 32'hFFFF_F123);
		rchk("reload pending", `IWDG_OFS_STAT, 32'h2);
		wait_clr(`IWDG_STAT_RLD);
		rchk("reload applied", `IWDG_OFS_RLD, 32'h0000_0123);
		wr(`IWDG_OFS_KEY, 32'h0000_AAAA);
		wr(`IWDG_OFS_RLD, 32'h0000_0456);
		rchk("relocked status", `IWDG_OFS_STAT, 32'h0);
		rchk("relocked reload", `IWDG_OFS_RLD, 32'h0000_0123);
		done("protection");

		wr(`IWDG_OFS_KEY, 32'h0000_5555);
		wr(`IWDG_OFS_PSC, 32'h0000_0007);
		rchk("divider pending", `IWDG_OFS_STAT, 32'h1);
		wait_clr(`IWDG_STAT_PSC);
		rchk("divider applied", `IWDG_OFS_PSC, 32'h0000_0007);
		wr(`IWDG_OFS_WND, 32'h0000_0100);
		rchk("window pending", `IWDG_OFS_STAT, 32'h4);
		wr(`IWDG_OFS_WND, 32'h0000_0200);
		wait_clr(`IWDG_STAT_WND);
		rchk("window kept", `IWDG_OFS_WND, 32'h0000_0100);
		done("updates");

		// each run starts with a mid-run reset that clears everything set above
		expiry("expiry div4", 32'h0000_0000, TICKS_EXP);
		expiry("expiry div8", 32'h0000_0001, RLD_SHORT * 8);

		do_reset(2);
		wr(`IWDG_OFS_KEY, 32'h0000_5555);
		wr(`IWDG_OFS_WND, 32'h0000_0010);
		wait_clr(`IWDG_STAT_WND);
		wr(`IWDG_OFS_KEY, 32'h0000_CCCC);
		check("no early reset", {31'h0, rst_req}, 32'h0);
		wr(`IWDG_OFS_KEY, 32'h0000_AAAA);
		@(negedge ref_clk);
		check("window violation", {31'h0, rst_req}, 32'h1);
		done("window");
		print_verdict();
	end

	// whole run takes about 6 us; a hang is cut well after that
	initial begin
		#100us;
		bad_count++;
		$display("watchdog expired before the tests ended");
		print_verdict();
	end

endmodule : tb

`default_nettype wire
